/* File: core/sad_pkg.sv */
// constants for the system address decoder
package sad_pkg;
  localparam int ADDR_W = 32;
  localparam logic [31:0] SLOW_BASE_0 = 32'h0000_0000;
  localparam logic [31:0] SLOW_BASE_1 = 32'h0400_0000;
  localparam logic [31:0] SLOW_BASE_2 = 32'h0800_0000;
  localparam logic [31:0] SLOW_BASE_3 = 32'h0C00_0000;
  localparam logic [31:0] SLOW_SIZE = 32'h0200_0000;
  localparam logic [31:0] SDRAM_BASE = 32'h1000_0000;
  localparam logic [31:0] SDRAM_SIZE = 32'h0400_0000;
  localparam logic [31:0] SRAM_BASE = 32'h2000_0000;
  localparam logic [31:0] SRAM_WINDOW = 32'h0008_0000;
  localparam logic [31:0] SRAM_FILLED = 32'h0003_0000;
  localparam logic [31:0] HPORT_RAM_BASE = 32'hE000_0000;
  localparam logic [31:0] HPORT_RAM_SIZE = 32'h0100_0000;
  localparam logic [31:0] HPORT_REG_BASE = 32'hE102_0000;
  localparam logic [31:0] HPORT_REG_SIZE = 32'h0000_0004;
  localparam logic [31:0] PUB_SEG_BASE = 32'hFFFB_0000;
  localparam logic [31:0] PRIV_SEG_BASE = 32'hFFFE_0000;
  localparam logic [31:0] SEG_SIZE = 32'h0002_0000;
  localparam int PERIPH_SLOT_BITS = 11;
  localparam logic [1:0] SZ_8 = 2'h0;
  localparam logic [1:0] SZ_16 = 2'h1;
  localparam logic [1:0] SZ_32 = 2'h2;
  localparam logic [2:0] ALLOW_ALL = 3'h7;
  localparam logic [2:0] ALLOW_8_16 = 3'h3;
  localparam logic [2:0] ALLOW_16_32 = 3'h6;
  localparam logic [2:0] ALLOW_16 = 3'h2;
  localparam logic [1:0] SWAP_IDX_A = 2'h0;
  localparam logic [1:0] SWAP_IDX_B = 2'h3;
  typedef enum logic [2:0] {
    TGT_NONE, TGT_SLOW, TGT_SDRAM, TGT_SRAM, TGT_PUB, TGT_PRIV, TGT_HPORT
  } sad_target_t;
  typedef enum {BOOT_WAIT, BOOT_HELD} sad_boot_st_t;
endpackage : sad_pkg

/* File: core/sad_window.sv */
// one address window hit detector with width check
`timescale 1ns/1ns
module sad_window #(
  parameter logic [31:0] BASE = 32'h0,
  parameter logic [31:0] SIZE = 32'h1,
  parameter logic [2:0] ALLOW = 3'h7
) (
  input wire logic [31:0] addr,
  input wire logic [1:0] size,
  output logic hit,
  output logic width_ok
);
  wire logic [31:0] offset = addr - BASE;
  assign hit = (addr >= BASE) && (offset < SIZE);
  assign width_ok = (size <= sad_pkg::SZ_32) ? ALLOW[size] : 1'b0;
endmodule : sad_window

/* File: core/sad_boot_latch.sv */
// boot select capture, held from reset release onward
`timescale 1ns/1ns
module sad_boot_latch (
  input wire logic clk,
  input wire logic rst,
  input wire logic boot_select_pin,
  output logic boot_level_field
);
  sad_pkg::sad_boot_st_t state_r;
  logic level_r;
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state_r <= sad_pkg::BOOT_WAIT;
      level_r <= boot_select_pin;
    end
    else
    begin
      case (state_r)
        sad_pkg::BOOT_WAIT: state_r <= sad_pkg::BOOT_HELD;
        sad_pkg::BOOT_HELD: state_r <= sad_pkg::BOOT_HELD;
        default: state_r <= sad_pkg::BOOT_HELD;
      endcase
    end
  end
  assign boot_level_field = level_r;
  chk_boot_stays_put: assert property (@(posedge clk) disable iff (rst)
    $stable(level_r)) else $error("boot level changed after reset");
endmodule : sad_boot_latch

/* File: core/sad_decoder.sv */
// system address decoder: request address to target selection
// Operation
// - four slow-memory chip selects, each covering a 32 MB window
// - SDRAM window of 64 MB at 1000_0000 goes to fast interface
// - internal SRAM window 512 KB, only first 192 KB at 2000_0000 routed
// - boot select high during reset swaps chip select 0 and 3 spaces
// - captured boot level is readable as the boot level field
// - boot level captured only at reset, later pin changes ignored
// - SDRAM and SRAM are selected internally, no external select pin
// - chip selects at 0000_0000, 0400_0000, 0800_0000, 0C00_0000 with gaps
// - widths 8/16/32 for selects and SRAM, only 8/16 for SDRAM
// - peripherals in public and private segments, 2 KB per peripheral
// - host-port RAM 16 MB at E000_0000, 16/32-bit accesses
// - host-port registers E102_0000..E102_0003, 16-bit accesses
`timescale 1ns/1ns
module sad_decoder (
  input wire logic clk,
  input wire logic rst,
  input wire logic boot_select_pin,
  input wire logic req_valid,
  input wire logic [31:0] req_addr,
  input wire logic [1:0] req_size,
  output logic [3:0] slow_select,
  output logic slow_memory_interface_sel,
  output logic sdram_sel,
  output logic sram_sel,
  output logic public_periph_strobe,
  output logic private_periph_strobe,
  output logic dsp_host_port_sel,
  output logic [31:0] sel_offset,
  output logic [4:0] periph_slot,
  output logic width_err,
  output logic unmapped,
  output logic boot_level_field
);
  // ----------------------------------------
  // boot capture
  // ----------------------------------------
  logic boot_lvl;
  sad_boot_latch u_boot (
    .clk(clk),
    .rst(rst),
    .boot_select_pin(boot_select_pin),
    .boot_level_field(boot_lvl)
  );

  // ----------------------------------------
  // window hits
  // ----------------------------------------
  localparam logic [31:0] SLOW_BASES [4] = '{sad_pkg::SLOW_BASE_0, sad_pkg::SLOW_BASE_1,
    sad_pkg::SLOW_BASE_2, sad_pkg::SLOW_BASE_3};
  wire logic [3:0] cs_hit;
  wire logic [3:0] cs_ok;
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_cs
      sad_window #(.BASE(SLOW_BASES[gi]), .SIZE(sad_pkg::SLOW_SIZE),
        .ALLOW(sad_pkg::ALLOW_ALL)) u_win (
        .addr(req_addr),
        .size(req_size),
        .hit(cs_hit[gi]),
        .width_ok(cs_ok[gi])
      );
    end
  endgenerate
  wire logic sd_hit, sd_ok, sr_hit, sr_ok, hr_hit, hr_ok, hg_hit, hg_ok;
  wire logic pub_hit, pub_ok, prv_hit, prv_ok;
  sad_window #(.BASE(sad_pkg::SDRAM_BASE), .SIZE(sad_pkg::SDRAM_SIZE),
    .ALLOW(sad_pkg::ALLOW_8_16)) u_sd (
    .addr(req_addr),
    .size(req_size),
    .hit(sd_hit),
    .width_ok(sd_ok)
  );
  sad_window #(.BASE(sad_pkg::SRAM_BASE), .SIZE(sad_pkg::SRAM_FILLED),
    .ALLOW(sad_pkg::ALLOW_ALL)) u_sr (
    .addr(req_addr),
    .size(req_size),
    .hit(sr_hit),
    .width_ok(sr_ok)
  );
  sad_window #(.BASE(sad_pkg::HPORT_RAM_BASE), .SIZE(sad_pkg::HPORT_RAM_SIZE),
    .ALLOW(sad_pkg::ALLOW_16_32)) u_hr (
    .addr(req_addr),
    .size(req_size),
    .hit(hr_hit),
    .width_ok(hr_ok)
  );
  sad_window #(.BASE(sad_pkg::HPORT_REG_BASE), .SIZE(sad_pkg::HPORT_REG_SIZE),
    .ALLOW(sad_pkg::ALLOW_16)) u_hg (
    .addr(req_addr),
    .size(req_size),
    .hit(hg_hit),
    .width_ok(hg_ok)
  );
  sad_window #(.BASE(sad_pkg::PUB_SEG_BASE), .SIZE(sad_pkg::SEG_SIZE),
    .ALLOW(sad_pkg::ALLOW_ALL)) u_pub (
    .addr(req_addr),
    .size(req_size),
    .hit(pub_hit),
    .width_ok(pub_ok)
  );
  sad_window #(.BASE(sad_pkg::PRIV_SEG_BASE), .SIZE(sad_pkg::SEG_SIZE),
    .ALLOW(sad_pkg::ALLOW_ALL)) u_prv (
    .addr(req_addr),
    .size(req_size),
    .hit(prv_hit),
    .width_ok(prv_ok)
  );

  // ----------------------------------------
  // boot swap and selection
  // ----------------------------------------
  // swap bits 0 and 3 when boot level is high
  wire logic [3:0] cs_map = boot_lvl ? {cs_hit[0], cs_hit[2:1], cs_hit[3]} : cs_hit;
  wire logic [3:0] cs_ok_any = cs_ok & cs_hit;
  wire logic any_cs = |cs_hit;
  wire logic hport_hit = hr_hit | hg_hit;
  wire logic any_hit = any_cs | sd_hit | sr_hit | hport_hit | pub_hit | prv_hit;
  wire logic w_ok = (|cs_ok_any) | (sd_hit & sd_ok) | (sr_hit & sr_ok) | (hr_hit & hr_ok)
    | (hg_hit & hg_ok) | (pub_hit & pub_ok) | (prv_hit & prv_ok);
  wire logic go = req_valid & any_hit;
  // offset is taken against the physical window, before the swap
  logic [1:0] cs_sel_idx;
  wire logic [31:0] cs_base = SLOW_BASES[cs_sel_idx];
  always_comb
  begin
    cs_sel_idx = 2'h0;
    for (int i = 0; i < 4; i++)
      if (cs_hit[i])
        cs_sel_idx = 2'(i);
  end
  wire logic [31:0] base_sel = any_cs ? cs_base
    : sd_hit ? sad_pkg::SDRAM_BASE
    : sr_hit ? sad_pkg::SRAM_BASE
    : hr_hit ? sad_pkg::HPORT_RAM_BASE
    : hg_hit ? sad_pkg::HPORT_REG_BASE
    : pub_hit ? sad_pkg::PUB_SEG_BASE
    : prv_hit ? sad_pkg::PRIV_SEG_BASE : 32'h0000_0000;
  wire logic [31:0] off_nxt = go ? req_addr - base_sel : 32'h0000_0000;
  wire logic [16:0] seg_off = 17'(req_addr - base_sel);
  wire logic [4:0] slot_nxt = (go & (pub_hit | prv_hit))
    ? seg_off[sad_pkg::PERIPH_SLOT_BITS +: 5] : 5'h00;

  // ----------------------------------------
  // output registers
  // ----------------------------------------
  logic [3:0] slow_select_r;
  // each output is its own flop, so no decode glitch reaches a pin
  logic sdram_sel_r, sram_sel_r, pub_r, prv_r, hport_r, werr_r, unm_r;
  logic sms_r;
  logic [31:0] off_r;
  logic [4:0] slot_r;
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      slow_select_r <= 4'h0;
      sms_r <= 1'b0;
      sdram_sel_r <= 1'b0;
      sram_sel_r <= 1'b0;
      pub_r <= 1'b0;
      prv_r <= 1'b0;
      hport_r <= 1'b0;
      werr_r <= 1'b0;
      unm_r <= 1'b0;
      off_r <= 32'h0000_0000;
      slot_r <= 5'h00;
    end
    else
    begin
      slow_select_r <= req_valid ? cs_map : 4'h0;
      sms_r <= req_valid & any_cs;
      sdram_sel_r <= req_valid & sd_hit;
      sram_sel_r <= req_valid & sr_hit;
      pub_r <= req_valid & pub_hit;
      prv_r <= req_valid & prv_hit;
      hport_r <= req_valid & hport_hit;
      werr_r <= go & ~w_ok;
      unm_r <= req_valid & ~any_hit;
      off_r <= off_nxt;
      slot_r <= slot_nxt;
    end
  end
  assign slow_select = slow_select_r;
  assign slow_memory_interface_sel = sms_r;
  assign sdram_sel = sdram_sel_r;
  assign sram_sel = sram_sel_r;
  assign public_periph_strobe = pub_r;
  assign private_periph_strobe = prv_r;
  assign dsp_host_port_sel = hport_r;
  assign sel_offset = off_r;
  assign periph_slot = slot_r;
  assign width_err = werr_r;
  assign unmapped = unm_r;
  assign boot_level_field = boot_lvl;

  // ----------------------------------------
  // checks: window routing
  // ----------------------------------------
  chk_sdram_window: assert property (@(posedge clk) disable iff (rst)
    req_valid && req_addr >= 32'h1000_0000 && req_addr <= 32'h13FF_FFFF |=> sdram_sel
  ) else $error("sdram window missed");
  chk_sram_filled: assert property (@(posedge clk) disable iff (rst)
    req_valid && req_addr >= 32'h2003_0000 && req_addr <= 32'h2007_FFFF |=> !sram_sel && unmapped
  ) else $error("unpopulated sram selected");
  chk_sram_hit: assert property (@(posedge clk) disable iff (rst)
    req_valid && req_addr >= 32'h2000_0000 && req_addr <= 32'h2002_FFFF
      |=> sram_sel && !unmapped
  ) else $error("populated sram missed");
  chk_cs_swap: assert property (@(posedge clk) disable iff (rst)
    req_valid && req_addr < 32'h0200_0000
      |=> slow_select == (boot_level_field ? 4'h8 : 4'h1)
  ) else $error("boot swap wrong");
  chk_cs3_swap: assert property (@(posedge clk) disable iff (rst)
    req_valid && req_addr >= 32'h0C00_0000 && req_addr <= 32'h0DFF_FFFF
      |=> slow_select == (boot_level_field ? 4'h1 : 4'h8)
  ) else $error("boot swap wrong on the top window");
  chk_cs1_window: assert property (@(posedge clk) disable iff (rst)
    req_valid && req_addr >= 32'h0400_0000 && req_addr <= 32'h05FF_FFFF
      |=> slow_select == 4'h2 && slow_memory_interface_sel
  ) else $error("chip select 1 window missed");
  chk_cs2_window: assert property (@(posedge clk) disable iff (rst)
    req_valid && req_addr >= 32'h0800_0000 && req_addr <= 32'h09FF_FFFF
      |=> slow_select == 4'h4 && sel_offset == $past(req_addr) - 32'h0800_0000
  ) else $error("chip select 2 window wrong");
  chk_cs_gap: assert property (@(posedge clk) disable iff (rst)
    req_valid && req_addr[25] && req_addr < 32'h1000_0000 |=> slow_select == 4'h0 && unmapped
  ) else $error("gap selected a chip");
  chk_slow_or: assert property (@(posedge clk) disable iff (rst)
    slow_memory_interface_sel == (|slow_select)
  ) else $error("slow interface select disagrees with chip selects");
  chk_no_ext_select: assert property (@(posedge clk) disable iff (rst)
    sdram_sel || sram_sel |-> slow_select == 4'h0 && !slow_memory_interface_sel
  ) else $error("chip select raised for an internal decode");
  chk_one_target: assert property (@(posedge clk) disable iff (rst)
    $onehot0({|slow_select, sdram_sel, sram_sel, public_periph_strobe,
      private_periph_strobe, dsp_host_port_sel, unmapped})
  ) else $error("more than one target");
  chk_hport_regs: assert property (@(posedge clk) disable iff (rst)
    req_valid && req_addr >= 32'hE102_0000 && req_addr <= 32'hE102_0003 |=> dsp_host_port_sel
  ) else $error("host-port registers missed");
  chk_hport_reg_end: assert property (@(posedge clk) disable iff (rst)
    req_valid && req_addr == 32'hE102_0004 |=> unmapped && !dsp_host_port_sel
  ) else $error("host-port register range too long");
  chk_hport_io_gap: assert property (@(posedge clk) disable iff (rst)
    req_valid && req_addr[31:17] == 15'h7080
      |=> unmapped && !dsp_host_port_sel
  ) else $error("undecoded host-port space selected");
  chk_periph_slot: assert property (@(posedge clk) disable iff (rst)
    req_valid && req_addr[31:16] == 16'hFFFB
      |=> public_periph_strobe && periph_slot == $past(req_addr[15:11])
  ) else $error("public slot wrong");
  chk_pub_seg_top: assert property (@(posedge clk) disable iff (rst)
    req_valid && req_addr[31:16] == 16'hFFFC
      |=> public_periph_strobe && !private_periph_strobe
  ) else $error("upper public segment missed");
  chk_priv_seg: assert property (@(posedge clk) disable iff (rst)
    req_valid && req_addr >= 32'hFFFE_0000
      |=> private_periph_strobe && periph_slot == $past(req_addr[15:11])
  ) else $error("private slot wrong");
  chk_reserved_hole: assert property (@(posedge clk) disable iff (rst)
    req_valid && req_addr[31:16] == 16'hFFFD
      |=> unmapped && !public_periph_strobe && !private_periph_strobe
  ) else $error("reserved peripheral hole selected");

  // ----------------------------------------
  // checks: widths, offsets and idle cycles
  // ----------------------------------------
  chk_sdram_width: assert property (@(posedge clk) disable iff (rst)
    req_valid && req_size == 2'h2 && req_addr[31:26] == 6'h04 |=> width_err
  ) else $error("32-bit sdram not flagged");
  chk_sdram_narrow: assert property (@(posedge clk) disable iff (rst)
    req_valid && req_size <= 2'h1 && req_addr[31:26] == 6'h04 |=> sdram_sel && !width_err
  ) else $error("narrow sdram access flagged");
  chk_cs_widths: assert property (@(posedge clk) disable iff (rst)
    req_valid && req_size <= 2'h2 && req_addr[31:28] == 4'h0 && !req_addr[25]
      |=> slow_memory_interface_sel && !width_err
  ) else $error("legal chip select width flagged");
  chk_hport_ram: assert property (@(posedge clk) disable iff (rst)
    req_valid && req_addr[31:24] == 8'hE0 && req_size == 2'h0 |=> dsp_host_port_sel && width_err
  ) else $error("host-port byte access not flagged");
  chk_hport_ram_ok: assert property (@(posedge clk) disable iff (rst)
    req_valid && req_addr[31:24] == 8'hE0 && (req_size == 2'h1 || req_size == 2'h2)
      |=> dsp_host_port_sel && !width_err && sel_offset == {8'h00, $past(req_addr[23:0])}
  ) else $error("host-port ram access wrong");
  chk_hport_reg_width: assert property (@(posedge clk) disable iff (rst)
    req_valid && req_addr[31:2] == 30'h3840_8000 && req_size == 2'h1
      |=> dsp_host_port_sel && !width_err
  ) else $error("16-bit host-port register access flagged");
  chk_unmapped_quiet: assert property (@(posedge clk) disable iff (rst)
    unmapped |-> !width_err && sel_offset == 32'h0000_0000 && periph_slot == 5'h00
  ) else $error("unmapped request carries a width error or offset");
  chk_idle_quiet: assert property (@(posedge clk) disable iff (rst)
    !req_valid |=> !slow_memory_interface_sel && !sdram_sel && !sram_sel && !unmapped
      && !public_periph_strobe && !private_periph_strobe && !dsp_host_port_sel
  ) else $error("select raised without a request");
endmodule : sad_decoder

/* File: bench/sad_master_model.sv */
// bus master model issuing one addressed request per command
`timescale 1ns/1ns
module sad_master_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic cmd_valid,
  input wire logic [31:0] cmd_addr,
  input wire logic [1:0] cmd_size,
  output logic req_valid,
  output logic [31:0] req_addr,
  output logic [1:0] req_size
);
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      req_valid <= 1'b0;
      req_addr <= 32'h0;
      req_size <= 2'h0;
    end
    else if (cmd_valid)
    begin
      // address and width pass exactly as the bench commands
      req_valid <= 1'b1;
      req_addr <= cmd_addr;
      req_size <= cmd_size;
    end
    else
    begin
      // released bus keeps changing
      req_valid <= 1'b0;
      req_addr <= ~req_addr;
      req_size <= ~req_size;
    end
  end
endmodule : sad_master_model

/* File: bench/tb.sv */
// self-checking bench for the system address decoder
`timescale 1ns/1ns
module tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic boot_pin = 1'b1;
  logic cmd_valid = 1'b0;
  logic [31:0] cmd_addr = 32'h0;
  logic [1:0] cmd_size = 2'h0;
  logic req_valid;
  logic [31:0] req_addr;
  logic [1:0] req_size;
  logic [3:0] slow_select;
  logic sms, sdram_sel, sram_sel, pub_s, priv_s, hp_sel, werr, unm, blf;
  logic [31:0] sel_offset;
  logic [4:0] periph_slot;
  logic [43:0] obs;
  int err_count = 0;
  int num_checks = 0;
  assign obs = {sms, slow_select, sdram_sel, sram_sel, pub_s, priv_s, hp_sel, werr, unm,
    sel_offset};
  always #2 clk = ~clk;
  sad_master_model sad_master_model_inst (.clk(clk), .rst(rst), .cmd_valid(cmd_valid),
    .cmd_addr(cmd_addr), .cmd_size(cmd_size), .req_valid(req_valid), .req_addr(req_addr),
    .req_size(req_size));
  sad_decoder sad_decoder_inst (.clk(clk), .rst(rst), .boot_select_pin(boot_pin),
    .req_valid(req_valid), .req_addr(req_addr), .req_size(req_size),
    .slow_select(slow_select), .slow_memory_interface_sel(sms), .sdram_sel(sdram_sel),
    .sram_sel(sram_sel), .public_periph_strobe(pub_s), .private_periph_strobe(priv_s),
    .dsp_host_port_sel(hp_sel), .sel_offset(sel_offset), .periph_slot(periph_slot),
    .width_err(werr), .unmapped(unm), .boot_level_field(blf));
  // ---------------------------------
  // shared tasks
  // ---------------------------------
  task automatic cmp(input logic [43:0] got, input logic [43:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp
  task automatic acc(input logic [31:0] a, input logic [1:0] s, input logic [10:0] e,
    input logic [31:0] off);
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_addr <= a;
    cmd_size <= s;
    @(posedge clk);
    cmd_valid <= 1'b0;
    @(posedge clk);
    #1;
    cmp(obs, {|e[10:7], e, off});
  endtask : acc
  task automatic do_reset(input logic pin);
    @(posedge clk);
    rst <= 1'b1;
    boot_pin <= pin;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    cmp(obs, 44'h0);
    cmp({43'h0, blf}, {43'h0, pin});
  endtask : do_reset
  task automatic end_sim;
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : end_sim
  // ---------------------------------
  // scenarios
  // ---------------------------------
  task automatic t_boot_swap;
    @(posedge clk);
    boot_pin <= 1'b0;
    acc(32'h0000_0000, sad_pkg::SZ_32, 11'h400, 32'h0);
    acc(32'h0DFF_FFFC, sad_pkg::SZ_32, 11'h080, 32'h01FF_FFFC);
    cmp({43'h0, blf}, 44'h1);
  endtask : t_boot_swap
  task automatic t_slow;
    acc(sad_pkg::SLOW_BASE_1, sad_pkg::SZ_8, 11'h100, 32'h0);
    acc(32'h09FF_FFFE, sad_pkg::SZ_16, 11'h200, 32'h01FF_FFFE);
    for (int i = 0; i < 4; i++)
      acc(32'h0400_0000 * i + sad_pkg::SLOW_SIZE, sad_pkg::SZ_8, 11'h001, 32'h0);
  endtask : t_slow
  task automatic t_sdram;
    acc(32'h1000_0010, sad_pkg::SZ_16, 11'h040, 32'h10);
    @(posedge clk);
    #1;
    cmp(obs, 44'h0);
    acc(32'h13FF_FFFF, sad_pkg::SZ_8, 11'h040, 32'h03FF_FFFF);
    acc(32'h1000_0000, sad_pkg::SZ_32, 11'h042, 32'h0);
    acc(32'h1400_0000, sad_pkg::SZ_16, 11'h001, 32'h0);
  endtask : t_sdram
  task automatic t_sram;
    acc(32'h2000_0000, sad_pkg::SZ_32, 11'h020, 32'h0);
    acc(32'h2002_FFFF, sad_pkg::SZ_8, 11'h020, 32'h0002_FFFF);
    acc(32'h2003_0000, sad_pkg::SZ_8, 11'h001, 32'h0);
  endtask : t_sram
  task automatic t_hport;
    acc(32'hE0FF_FFFC, sad_pkg::SZ_32, 11'h004, 32'h00FF_FFFC);
    acc(32'hE000_0000, sad_pkg::SZ_8, 11'h006, 32'h0);
    acc(32'hE102_0002, sad_pkg::SZ_16, 11'h004, 32'h2);
    acc(32'hE102_0000, sad_pkg::SZ_32, 11'h006, 32'h0);
    acc(32'hE102_0004, sad_pkg::SZ_16, 11'h001, 32'h0);
  endtask : t_hport
  task automatic t_periph;
    acc(32'hFFFB_0800, sad_pkg::SZ_8, 11'h010, 32'h800);
    cmp({39'h0, periph_slot}, 44'h1);
    acc(32'hFFFE_1004, sad_pkg::SZ_32, 11'h008, 32'h1004);
    cmp({39'h0, periph_slot}, 44'h2);
    acc(32'hFFFD_0000, sad_pkg::SZ_16, 11'h001, 32'h0);
  endtask : t_periph
  task automatic t_no_swap;
    do_reset(1'b0);
    acc(32'h0000_0004, sad_pkg::SZ_32, 11'h080, 32'h4);
    acc(sad_pkg::SLOW_BASE_3, sad_pkg::SZ_8, 11'h400, 32'h0);
  endtask : t_no_swap
  initial
  begin
    do_reset(1'b1);
    t_boot_swap();
    t_slow();
    t_sdram();
    t_sram();
    t_hport();
    t_periph();
    t_no_swap();
    end_sim();
  end
  initial
  begin
    repeat (5000) @(posedge clk);
    err_count++;
    end_sim();
  end
endmodule : tb
